/* hw/ppp_pkg.sv */
// Package for the parallel programming port: codes, layouts, timing.
// Assumes a single 100 MHz clock domain in the importing design.
package ppp_pkg;
  // Strobe action select codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  // Command byte codes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_ID = 8'h08;
  localparam logic [7:0] CMD_RD_FL = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;
  // Fuse and lock layouts, reset values
  localparam logic [7:0] FUSE_RSVD_MASK = 8'h88;
  localparam logic [7:0] LOCK_RSVD_MASK = 8'hC0;
  localparam logic [7:0] FUSE_RESET = 8'hDA;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int PAGE_HI_BITS = 5;
  localparam int WORD_BITS = 6;
  localparam int EE_AW = 9;
  localparam int ID_AW = 2;
  // Operation times
  localparam int CLK_MHZ = 100;
  localparam int T_BYTE_US = 1000;
  localparam int T_ERASE_US = 16000;
  localparam int T_FLASH_US = 8000;
  localparam int BYTE_CYC = T_BYTE_US * CLK_MHZ;
  localparam int ERASE_CYC = T_ERASE_US * CLK_MHZ;
  localparam int FLASH_CYC = T_FLASH_US * CLK_MHZ;
endpackage

/* hw/ppp_port.sv */
// Parallel programming port: command/address/data loads, page buffer,
// flash and EEPROM arrays, fuse and lock bits, ready/busy reporting.
// Assumes all pins are synchronous to mclk_i; strobes last >1 cycle.
`timescale 1ns/1ps
// Overview of operation
// - Crystal pulse loads address, data, command or idles
// - Codes select erase, fuse write, lock write
// - Codes select flash write, EEPROM write
// - Codes select flash read, EEPROM read
// - Codes select identification or fuse/lock read
// - Ready low while busy, high when idle
// - Byte select picks low or high byte
// - Drive data bus only while output enabled
// - Write strobe or read performs loaded command
// - Erase clears arrays and locks, keeps fuses
// - Write strobe starts erase, ready drops
// - Page strobe latches last data byte to buffer
// - Page number from high byte and low bits
// - Write strobe programs whole page, busy meanwhile
// - Null command resets internal write signals
// - EEPROM write programs low data byte
// - Command and address kept across operations
// - Read presents flash low/high or EEPROM byte
// - Fuse byte: zero programs, reserved bits one
// - Lock byte: zero programs, only erase releases
// - Fuse/lock read returns fuses or locks
module ppp_port #(
  parameter int ERASE_CYC = ppp_pkg::ERASE_CYC, // Erase duration
  parameter int FLASH_CYC = ppp_pkg::FLASH_CYC, // Page write duration
  parameter int BYTE_CYC = ppp_pkg::BYTE_CYC, // Byte/fuse/lock duration
  parameter logic [7:0] ID0 = 8'h5A, // Arbitrary identification value
  parameter logic [7:0] ID1 = 8'h3C, // Arbitrary identification value
  parameter logic [7:0] ID2 = 8'h01 // Arbitrary identification value
) (
  input wire logic mclk_i, // 100 MHz clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic crystal_in_strobe_i, // Load strobe
  input wire logic strobe_action_sel_0_i, // Action select bit 0
  input wire logic strobe_action_sel_1_i, // Action select bit 1
  input wire logic byte_half_sel_i, // 0 low byte, 1 high byte
  input wire logic byte_sel_second_i, // Held low, unused
  input wire logic buffer_latch_strobe_i, // Page buffer latch
  input wire logic wr_n_i, // Write strobe, active low
  input wire logic oe_n_i, // Output enable, active low
  input wire logic [7:0] data_i, // Data bus in
  output logic [7:0] data_o, // Data bus out
  output logic data_oe_o, // Data bus drive enable
  output logic op_done_flag_o // 1 ready, 0 busy
);
  localparam int FW = ppp_pkg::PAGE_HI_BITS + 2 + ppp_pkg::WORD_BITS;
  localparam int NW = 1 << FW;
  localparam int PW = 1 << ppp_pkg::WORD_BITS;
  localparam int NE = 1 << ppp_pkg::EE_AW;
  localparam int ID_AW_M = ppp_pkg::ID_AW - 1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ERASE = 4'h2,
    ST_PAGE = 4'h4,
    ST_WAIT = 4'h8
  } ppp_state_e;

  // Memories are arrays; not reset; flash and EEPROM unknown until a full erase, page buffer until latched
  logic [15:0] flash_q [NW];
  logic [15:0] pbuf_q [PW];
  logic [7:0] ee_q [NE];

  ppp_state_e st_q, st_d;
  logic [7:0] cmd_q, cmd_d, alo_q, alo_d, ahi_q, ahi_d;
  logic [7:0] dlo_q, dlo_d, dhi_q, dhi_d, fuse_q, fuse_d, lock_q, lock_d;
  logic [31:0] cnt_q, cnt_d;
  logic xs_q, ps_q, ws_q, wr_arm_q, wr_arm_d, rdy_q, rdy_d;
  logic [7:0] dout_q, dout_d;
  logic oe_q, oe_d;
  logic xrise, prise, wfall;
  logic [1:0] act;
  logic [6:0] page;
  logic [FW-1:0] faddr;
  logic [ppp_pkg::EE_AW-1:0] eaddr;

  function automatic logic [31:0] dur(input int c);
    dur = (c < 1) ? 32'h1 : 32'(c);
  endfunction

  assign act = {strobe_action_sel_1_i, strobe_action_sel_0_i};
  assign xrise = crystal_in_strobe_i & ~xs_q;
  assign prise = buffer_latch_strobe_i & ~ps_q;
  assign wfall = ~wr_n_i & ws_q;
  assign page = {ahi_q[ppp_pkg::PAGE_HI_BITS-1:0], alo_q[7:6]};
  assign faddr = {page, alo_q[ppp_pkg::WORD_BITS-1:0]};
  assign eaddr = {ahi_q[0], alo_q};

  // Edge history of the strobes
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xs_q <= 1'b0;
      ps_q <= 1'b0;
      ws_q <= 1'b1;
    end else begin
      xs_q <= crystal_in_strobe_i;
      ps_q <= buffer_latch_strobe_i;
      ws_q <= wr_n_i;
    end
  end

  // Loads, command execution and busy sequencing
  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    alo_d = alo_q;
    ahi_d = ahi_q;
    dlo_d = dlo_q;
    dhi_d = dhi_q;
    fuse_d = fuse_q;
    lock_d = lock_q;
    cnt_d = cnt_q;
    wr_arm_d = wr_arm_q;
    rdy_d = rdy_q;
    if (xrise) begin
      unique case (act)
        ppp_pkg::ACT_ADDR: begin
          if (byte_half_sel_i) begin
            ahi_d = data_i;
          end else begin
            alo_d = data_i;
          end
        end
        ppp_pkg::ACT_DATA: begin
          if (byte_half_sel_i) begin
            dhi_d = data_i;
          end else begin
            dlo_d = data_i;
          end
        end
        ppp_pkg::ACT_CMD: begin
          cmd_d = data_i;
          wr_arm_d = (data_i != ppp_pkg::CMD_NOP);
        end
        ppp_pkg::ACT_IDLE: begin
        end
      endcase
    end
    unique case (st_q)
      ST_IDLE: begin
        // Busy check keeps a running operation undisturbed
        if (wfall && rdy_q && wr_arm_q) begin
          unique case (cmd_q)
            ppp_pkg::CMD_ERASE: begin
              st_d = ST_ERASE;
              cnt_d = dur(ERASE_CYC);
              rdy_d = 1'b0;
            end
            ppp_pkg::CMD_WR_FLASH: begin
              st_d = ST_PAGE;
              cnt_d = dur(FLASH_CYC);
              rdy_d = 1'b0;
            end
            ppp_pkg::CMD_WR_EE, ppp_pkg::CMD_WR_FUSE,
            ppp_pkg::CMD_WR_LOCK: begin
              st_d = ST_WAIT;
              cnt_d = dur(BYTE_CYC);
              rdy_d = 1'b0;
              if (cmd_q == ppp_pkg::CMD_WR_FUSE) begin
                fuse_d = dlo_q | ppp_pkg::FUSE_RSVD_MASK;
              end
              if (cmd_q == ppp_pkg::CMD_WR_LOCK) begin
                lock_d = lock_q & (dlo_q | ppp_pkg::LOCK_RSVD_MASK);
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_ERASE, ST_PAGE, ST_WAIT: begin
        cnt_d = cnt_q - 32'h1;
        if (cnt_q == 32'h1) begin
          st_d = ST_IDLE;
          rdy_d = 1'b1;
          if (st_q == ST_ERASE) begin
            lock_d = ppp_pkg::LOCK_RESET;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
        rdy_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= ST_IDLE;
      cmd_q <= ppp_pkg::CMD_NOP;
      alo_q <= 8'h00;
      ahi_q <= 8'h00;
      dlo_q <= 8'h00;
      dhi_q <= 8'h00;
      fuse_q <= ppp_pkg::FUSE_RESET;
      lock_q <= ppp_pkg::LOCK_RESET;
      cnt_q <= 32'h0;
      wr_arm_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      alo_q <= alo_d;
      ahi_q <= ahi_d;
      dlo_q <= dlo_d;
      dhi_q <= dhi_d;
      fuse_q <= fuse_d;
      lock_q <= lock_d;
      cnt_q <= cnt_d;
      wr_arm_q <= wr_arm_d;
      rdy_q <= rdy_d;
    end
  end

  // Array updates; data lands at the end of each timed operation
  always_ff @(posedge mclk_i) begin
    if (prise) begin
      if (byte_half_sel_i) begin
        pbuf_q[alo_q[ppp_pkg::WORD_BITS-1:0]][15:8] <= dhi_q;
      end else begin
        pbuf_q[alo_q[ppp_pkg::WORD_BITS-1:0]][7:0] <= dlo_q;
      end
    end
    if (st_q == ST_PAGE && cnt_q == 32'h1) begin
      for (int i = 0; i < PW; i++) begin
        flash_q[{page, ppp_pkg::WORD_BITS'(i)}] <= pbuf_q[i];
      end
    end
    if (st_q == ST_WAIT && cnt_q == 32'h1 &&
        cmd_q == ppp_pkg::CMD_WR_EE) begin
      ee_q[eaddr] <= dlo_q;
    end
    if (st_q == ST_ERASE && cnt_q == 32'h1) begin
      for (int i = 0; i < NW; i++) begin
        flash_q[i] <= {2{ppp_pkg::ERASED_BYTE}};
      end
      for (int i = 0; i < NE; i++) begin
        ee_q[i] <= ppp_pkg::ERASED_BYTE;
      end
    end
  end

  // Read path, registered so the pins come from flip-flops
  always_comb begin
    dout_d = 8'h00;
    oe_d = ~oe_n_i;
    unique case (cmd_q)
      ppp_pkg::CMD_RD_FLASH: begin
        dout_d = byte_half_sel_i ? flash_q[faddr][15:8] :
                 flash_q[faddr][7:0];
      end
      ppp_pkg::CMD_RD_EE: dout_d = ee_q[eaddr];
      ppp_pkg::CMD_RD_ID: begin
        unique case (alo_q[ID_AW_M:0])
          2'h0: dout_d = ID0;
          2'h1: dout_d = ID1;
          2'h2: dout_d = ID2;
          default: dout_d = 8'h00;
        endcase
      end
      ppp_pkg::CMD_RD_FL: begin
        dout_d = byte_half_sel_i ? lock_q : fuse_q;
      end
      default: dout_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dout_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  assign data_o = dout_q;
  assign data_oe_o = oe_q;
  assign op_done_flag_o = rdy_q;

  // Ready drops the cycle after an accepted erase write strobe
  chk_busy_on_wr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (st_q == ST_IDLE && wfall && rdy_q && wr_arm_q &&
     cmd_q == ppp_pkg::CMD_ERASE) |=> !op_done_flag_o)
    else $error("busy not raised on erase");
  chk_busy_state: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (st_q != ST_IDLE) |-> !rdy_q)
    else $error("ready high while busy");
  chk_fuse_rsvd: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (fuse_q & ppp_pkg::FUSE_RSVD_MASK) == ppp_pkg::FUSE_RSVD_MASK)
    else $error("fuse reserved bit cleared");
  chk_lock_only_erase: assert property (@(posedge mclk_i)
    disable iff (!nrst_i)
    ($rose(lock_q[0]) |-> $past(st_q) == ST_ERASE))
    else $error("lock released without erase");
  chk_oe_follows: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !oe_n_i |=> data_oe_o)
    else $error("bus not driven on output enable");
  chk_oe_release: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    oe_n_i |=> !data_oe_o)
    else $error("bus driven without output enable");
  chk_cmd_load: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (xrise && act == ppp_pkg::ACT_CMD) |=> cmd_q == $past(data_i))
    else $error("command not loaded");
  chk_cmd_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !(xrise && act == ppp_pkg::ACT_CMD) |=> $stable(cmd_q))
    else $error("command changed without load");
  chk_busy_ignore: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (st_q == ST_PAGE && cnt_q > 32'h1) |=> st_q == ST_PAGE)
    else $error("page write disturbed");
  chk_nop_disarm: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (xrise && act == ppp_pkg::ACT_CMD && data_i == ppp_pkg::CMD_NOP)
    |=> !wr_arm_q)
    else $error("null command left writes armed");
endmodule

/* dv/ppp_prog_model.sv */
// Programmer model driving the parallel programming port pins.
// Assumes tasks are entered just after a falling edge of mclk_i.
`timescale 1ns/1ps
module ppp_prog_model (
  input wire logic mclk_i, // Device clock
  input wire logic [7:0] dev_data_i, // Device bus out
  input wire logic dev_oe_i, // Device drives bus
  input wire logic ready_i, // Ready/busy flag
  output logic xtal_o, // Load strobe
  output logic [1:0] act_o, // Action select {1,0}
  output logic bh_o, // Byte half select
  output logic bs2_o, // Second byte select, held low
  output logic page_o, // Page latch strobe
  output logic wr_n_o, // Write strobe
  output logic oe_n_o, // Output enable
  output logic [7:0] bus_o // Resolved data bus
);
  logic [7:0] dq = 8'h00;
  logic drv = 1'b0;
  // Released bus shows inverse of last value, so stale reads cannot match
  assign bus_o = dev_oe_i ? dev_data_i : (drv ? dq : ~dq);
  // Idle pin levels
  initial begin
    xtal_o = 1'b0;
    act_o = 2'h3;
    bh_o = 1'b0;
    bs2_o = 1'b0;
    page_o = 1'b0;
    wr_n_o = 1'b1;
    oe_n_o = 1'b1;
  end
  // Strobes and setup held two cycles each, as the port asks
  task automatic hold2();
    repeat (2) @(negedge mclk_i);
  endtask
  // Load one byte by a load strobe pulse
  task automatic load(input logic [1:0] act, input logic bh,
                      input logic [7:0] d);
    act_o = act;
    bh_o = bh;
    dq = d;
    drv = 1'b1;
    hold2();
    xtal_o = 1'b1;
    hold2();
    xtal_o = 1'b0;
    hold2();
    drv = 1'b0;
    act_o = 2'h3;
  endtask
  // Latch the last data byte into the page buffer
  task automatic latch(input logic bh);
    bh_o = bh;
    hold2();
    page_o = 1'b1;
    hold2();
    page_o = 1'b0;
    hold2();
  endtask
  // Write pulse, then bounded wait for ready; busy seen while low
  task automatic write(output logic busy, output logic done);
    int n;
    wr_n_o = 1'b0;
    hold2();
    busy = ~ready_i;
    wr_n_o = 1'b1;
    done = 1'b0;
    for (n = 0; n < 300 && !done; n++) begin
      @(negedge mclk_i);
      done = ready_i;
    end
  endtask
  // Output-enabled read of one byte half
  task automatic read(input logic bh, output logic [7:0] d,
                      output logic oe);
    bh_o = bh;
    oe_n_o = 1'b0;
    hold2();
    d = bus_o;
    oe = dev_oe_i;
    oe_n_o = 1'b1;
    hold2();
  endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the parallel programming port.
// Assumes short operation counts; arrays only read after an erase.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  error_cnt++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic xtal, bh, bs2, page, wr_n, oe_n, doe, rdy, oe, busy, done;
  logic [1:0] act;
  logic [7:0] bus, dout, rd;
  int error_cnt = 0;
  int comparisons = 0;
  int i;
  // Arbitrary identification values, as the design's defaults
  localparam logic [7:0] IDS [3] = '{8'h5A, 8'h3C, 8'h01};
  always #5 mclk_i = ~mclk_i;
  ppp_port #(.ERASE_CYC(20), .FLASH_CYC(10), .BYTE_CYC(5)) i_dut (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .crystal_in_strobe_i(xtal),
    .strobe_action_sel_0_i(act[0]), .strobe_action_sel_1_i(act[1]),
    .byte_half_sel_i(bh), .byte_sel_second_i(bs2),
    .buffer_latch_strobe_i(page), .wr_n_i(wr_n), .oe_n_i(oe_n),
    .data_i(bus), .data_o(dout), .data_oe_o(doe), .op_done_flag_o(rdy));
  ppp_prog_model i_prog (.mclk_i(mclk_i), .dev_data_i(dout),
    .dev_oe_i(doe), .ready_i(rdy), .xtal_o(xtal), .act_o(act),
    .bh_o(bh), .bs2_o(bs2), .page_o(page), .wr_n_o(wr_n), .oe_n_o(oe_n),
    .bus_o(bus));
  // Single exit point for verdict
  task automatic report_and_stop();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    i_prog.load(2'h2, 1'b0, c);
  endtask
  task automatic rdchk(input logic h, input logic [7:0] exp);
    i_prog.read(h, rd, oe);
    `CHK(oe, 1'b1)
    `CHK(rd, exp)
  endtask
  // A hung operation ends the run at once
  task automatic wrchk(input logic exp_busy);
    i_prog.write(busy, done);
    `CHK(busy, exp_busy)
    if (done !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  // Main sequence
  initial begin
    repeat (5) @(negedge mclk_i);
    nrst_i = 1'b1;
    // Settle time after mode entry before the first load
    repeat (50) @(negedge mclk_i);
    @(negedge mclk_i);
    `CHK(rdy, 1'b1)
    `CHK(doe, 1'b0)
    cmd(ppp_pkg::CMD_RD_FL);
    rdchk(1'b0, 8'hDA);
    rdchk(1'b1, 8'hFF);
    `CHK(doe, 1'b0)
    i_prog.load(2'h3, 1'b0, 8'h80);
    rdchk(1'b0, 8'hDA);
    cmd(ppp_pkg::CMD_ERASE);
    wrchk(1'b1);
    cmd(ppp_pkg::CMD_WR_FUSE);
    i_prog.load(2'h1, 1'b0, 8'h00);
    wrchk(1'b1);
    cmd(ppp_pkg::CMD_WR_LOCK);
    i_prog.load(2'h1, 1'b0, 8'h15);
    wrchk(1'b1);
    cmd(ppp_pkg::CMD_RD_FL);
    rdchk(1'b0, 8'h88);
    rdchk(1'b1, 8'hD5);
    cmd(ppp_pkg::CMD_ERASE);
    wrchk(1'b1);
    cmd(ppp_pkg::CMD_RD_FL);
    rdchk(1'b0, 8'h88);
    rdchk(1'b1, 8'hFF);
    // Page 0x0D filled word by word; page 0x0E stays erased
    cmd(ppp_pkg::CMD_WR_FLASH);
    for (i = 0; i < 64; i++) begin
      i_prog.load(2'h0, 1'b0, {2'b01, i[5:0]});
      i_prog.load(2'h1, 1'b0, 8'h10 + 8'(i));
      i_prog.latch(1'b0);
      i_prog.load(2'h1, 1'b1, 8'hE0 + 8'(i));
      i_prog.latch(1'b1);
    end
    i_prog.load(2'h0, 1'b1, 8'h03);
    wrchk(1'b1);
    cmd(ppp_pkg::CMD_NOP);
    wrchk(1'b0);
    cmd(ppp_pkg::CMD_RD_FLASH);
    i_prog.load(2'h0, 1'b1, 8'h03);
    for (i = 0; i < 5; i++) begin
      i_prog.load(2'h0, 1'b0, {2'b01, i[5:0]});
      rdchk(1'b0, 8'h10 + 8'(i));
      rdchk(1'b1, 8'hE0 + 8'(i));
    end
    i_prog.load(2'h0, 1'b0, 8'h81);
    rdchk(1'b1, 8'hFF);
    // Two EEPROM bytes under one command load
    cmd(ppp_pkg::CMD_WR_EE);
    i_prog.load(2'h0, 1'b1, 8'h01);
    for (i = 0; i < 2; i++) begin
      i_prog.load(2'h0, 1'b0, 8'h34 + 8'(i));
      i_prog.load(2'h1, 1'b0, i == 0 ? 8'hA5 : 8'h5A);
      wrchk(1'b1);
    end
    cmd(ppp_pkg::CMD_RD_EE);
    for (i = 0; i < 2; i++) begin
      i_prog.load(2'h0, 1'b0, 8'h34 + 8'(i));
      rdchk(1'b0, i == 0 ? 8'hA5 : 8'h5A);
    end
    cmd(ppp_pkg::CMD_RD_ID);
    for (i = 0; i < 3; i++) begin
      i_prog.load(2'h0, 1'b0, 8'(i));
      rdchk(1'b0, IDS[i]);
    end
    report_and_stop();
  end
endmodule
